/* File: inc/sscb_pkg.sv */
// Purpose: Shared constants for the synchronous SRAM cycle and burst port
// Assumes: One clock, 4 byte lanes of 8 bits plus one parity bit each
// Notes: Widths are fixed; the parity option selects the 36-bit or 32-bit form
package sscb_pkg;
	localparam int LANES = 4;
	localparam int LANE_W = 8;
	localparam int LANE_PW = 9;
	localparam int DATA_W = LANES * LANE_PW;
	localparam int ADDR_W = 18;
	localparam int WORDS = 262144;
	localparam int BURST_LEN = 4;
	localparam logic [1:0] STEP_RST = 2'h0;
	localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
	localparam logic [LANES-1:0] STRB_RST = 4'hf;
	localparam int SEED_LSB = 0;
	localparam int SEED_MSB = 1;
	localparam int PAR_POS = 8;

	typedef enum logic [1:0] {
		SSCB_IDLE = 2'b00,
		SSCB_READ = 2'b01,
		SSCB_WRITE = 2'b10
	} sscb_cycle_t;
endpackage : sscb_pkg

/* File: src/sscb_mem.sv */
// Purpose: Word memory with per-lane write enables and registered read data
// Assumes: Single clock, write and read addresses given in the same cycle
// Notes: Clock enable freezes the read register as well
module sscb_mem (
	// Clock and enable
	input wire logic core_clk,
	input wire logic ce,
	// Write side
	input wire logic wr_en,
	input wire logic [sscb_pkg::ADDR_W-1:0] wr_addr,
	input wire logic [sscb_pkg::LANES-1:0] wr_lane,
	input wire logic [sscb_pkg::DATA_W-1:0] wr_data,
	// Read side
	input wire logic [sscb_pkg::ADDR_W-1:0] rd_addr,
	output logic [sscb_pkg::DATA_W-1:0] rd_data
);
	genvar g;
	generate
		for (g = 0; g < sscb_pkg::LANES; g++) begin : g_lane
			// One array per lane, so each array has a single writing process
			logic [sscb_pkg::LANE_PW-1:0] lane_mem [0:sscb_pkg::WORDS-1];
			always_ff @(posedge core_clk) begin
				if (ce && wr_en && wr_lane[g]) begin
					lane_mem[wr_addr] <= wr_data[g*sscb_pkg::LANE_PW +: sscb_pkg::LANE_PW];
				end
			end
			always_ff @(posedge core_clk) begin
				if (ce) begin
					rd_data[g*sscb_pkg::LANE_PW +: sscb_pkg::LANE_PW] <= lane_mem[rd_addr];
				end
			end
		end
	endgenerate
endmodule : sscb_mem

/* File: src/sscb_port.sv */
// Purpose: Cycle-type decode, burst addressing and lane writes of a pipelined SRAM port
// Assumes: All inputs synchronous to core_clk; chip enables and output enable handled outside
// Notes: Pipeline is address cycle, then data two edges later, for reads and writes alike
// Notes: Cycle type and strobes travel down the pipeline with their address
// Notes: Memory and read register are not reset; only the pipeline control is
// Notes: An advance with no load since reset is an idle cycle
// Notes on behaviour
// - Direction sampled only at address load
// - Direction low at load means write
// - Burst continuation keeps read or write type
// - Low strobes select lanes written
// - Burst order select low gives linear order
// - Burst order select high gives interleaved
// - Four byte lanes a to d, own strobes
// - Parity bits stored in 36-bit form only
// - Write data captured on rising edge
// - Load low loads address, high advances
// - Strobes taken with address, used later
// - Clock enable high freezes all state
// - Two address LSBs seed burst counter
module sscb_port #(
	parameter bit PARITY_EN = 1'b1
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_enable_n,
	// Address and control
	input wire logic advance_or_load_n,
	input wire logic read_write_n,
	input wire logic [sscb_pkg::ADDR_W-1:0] addr,
	input wire logic burst_order_select,
	// Byte write strobes, active low
	input wire logic byte_write_strobe_a_n,
	input wire logic byte_write_strobe_b_n,
	input wire logic byte_write_strobe_c_n,
	input wire logic byte_write_strobe_d_n,
	// Byte lanes in
	input wire logic [sscb_pkg::LANE_W-1:0] byte_lane_a_in,
	input wire logic [sscb_pkg::LANE_W-1:0] byte_lane_b_in,
	input wire logic [sscb_pkg::LANE_W-1:0] byte_lane_c_in,
	input wire logic [sscb_pkg::LANE_W-1:0] byte_lane_d_in,
	input wire logic [sscb_pkg::LANES-1:0] lane_parity_bit_in,
	// Byte lanes out
	output logic [sscb_pkg::LANE_W-1:0] byte_lane_a_out,
	output logic [sscb_pkg::LANE_W-1:0] byte_lane_b_out,
	output logic [sscb_pkg::LANE_W-1:0] byte_lane_c_out,
	output logic [sscb_pkg::LANE_W-1:0] byte_lane_d_out,
	output logic [sscb_pkg::LANES-1:0] lane_parity_bit_out,
	output logic [sscb_pkg::LANES-1:0] data_oe_n
);
	// =========================================================
	// Burst step decode
	// =========================================================
	// Low bits of a burst word address, from the load seed and the step count
	// Interleave gives a fixed pairing of words, linear a rotation from the seed
	function automatic logic [1:0] burst_addr(input logic [1:0] seed, input logic [1:0] step,
		input logic interleave);
		burst_addr = interleave ? (seed ^ step) : 2'(seed + step);
	endfunction : burst_addr

	// =========================================================
	// Pin decode
	// =========================================================
	wire logic ce = !clk_enable_n;
	wire logic load = !advance_or_load_n;

	// =========================================================
	// Address stage
	// =========================================================
	// Type, base and strobes change only at a load, so an advance can never
	// turn a read into a write; the controller must load to change direction.
	// The seed keeps the two low bits of the loaded address and the step
	// counter counts the advances since that load.
	sscb_pkg::sscb_cycle_t cyc_r, cyc_nxt;
	logic [sscb_pkg::ADDR_W-1:0] base_r, base_nxt;
	logic [1:0] seed_r, seed_nxt;
	logic [1:0] step_r, step_nxt;
	logic [sscb_pkg::LANES-1:0] strb_r, strb_nxt;

	wire logic [sscb_pkg::LANES-1:0] strb_in = {!byte_write_strobe_d_n, !byte_write_strobe_c_n,
		!byte_write_strobe_b_n, !byte_write_strobe_a_n};
	wire logic [1:0] seed_in = {addr[sscb_pkg::SEED_MSB], addr[sscb_pkg::SEED_LSB]};

	always_comb begin
		cyc_nxt = cyc_r;
		base_nxt = base_r;
		seed_nxt = seed_r;
		step_nxt = step_r;
		strb_nxt = strb_r;
		if (load) begin
			cyc_nxt = read_write_n ? sscb_pkg::SSCB_READ : sscb_pkg::SSCB_WRITE;
			base_nxt = addr;
			seed_nxt = seed_in;
			step_nxt = sscb_pkg::STEP_RST;
			strb_nxt = strb_in;
		end else begin
			// Wraps, so an advance past the fourth word repeats the same four
			step_nxt = 2'(step_r + 2'h1);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cyc_r <= sscb_pkg::SSCB_IDLE;
			base_r <= sscb_pkg::ADDR_RST;
			seed_r <= sscb_pkg::STEP_RST;
			step_r <= sscb_pkg::STEP_RST;
			strb_r <= sscb_pkg::STRB_RST;
		end else if (ce) begin
			cyc_r <= cyc_nxt;
			base_r <= base_nxt;
			seed_r <= seed_nxt;
			step_r <= step_nxt;
			strb_r <= strb_nxt;
		end
	end

	// Word address of the current cycle, low bits from the burst order
	wire logic [1:0] lsb_now = load ? seed_in :
		burst_addr(seed_r, step_nxt, burst_order_select);
	wire logic [sscb_pkg::ADDR_W-1:0] addr_now = load ? addr :
		{base_r[sscb_pkg::ADDR_W-1:2], lsb_now};
	wire sscb_pkg::sscb_cycle_t cyc_now = load ? cyc_nxt : cyc_r;
	wire logic [sscb_pkg::LANES-1:0] strb_now = load ? strb_in : strb_r;

	// =========================================================
	// Data pipeline: two edges from address to data
	// =========================================================
	// Stage one addresses the read, stage two the write and its lanes.
	// A write lands when its data is on the lanes, so a read of the same word
	// in the turnaround cycle still sees the older contents.
	sscb_pkg::sscb_cycle_t cyc_p1_r, cyc_p2_r;
	logic [sscb_pkg::ADDR_W-1:0] addr_p1_r, addr_p2_r;
	logic [sscb_pkg::LANES-1:0] strb_p1_r, strb_p2_r;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cyc_p1_r <= sscb_pkg::SSCB_IDLE;
			cyc_p2_r <= sscb_pkg::SSCB_IDLE;
			addr_p1_r <= sscb_pkg::ADDR_RST;
			addr_p2_r <= sscb_pkg::ADDR_RST;
			strb_p1_r <= sscb_pkg::STRB_RST;
			strb_p2_r <= sscb_pkg::STRB_RST;
		end else if (ce) begin
			cyc_p1_r <= cyc_now;
			cyc_p2_r <= cyc_p1_r;
			addr_p1_r <= addr_now;
			addr_p2_r <= addr_p1_r;
			strb_p1_r <= strb_now;
			strb_p2_r <= strb_p1_r;
		end
	end

	// =========================================================
	// Write data assembly and memory
	// =========================================================
	logic [sscb_pkg::LANE_W-1:0] lane_in [sscb_pkg::LANES];
	logic [sscb_pkg::DATA_W-1:0] wr_data;
	logic [sscb_pkg::DATA_W-1:0] rd_data;
	assign lane_in[0] = byte_lane_a_in;
	assign lane_in[1] = byte_lane_b_in;
	assign lane_in[2] = byte_lane_c_in;
	assign lane_in[3] = byte_lane_d_in;

	// In the 32-bit form the parity bits are neither stored nor returned
	genvar g;
	generate
		for (g = 0; g < sscb_pkg::LANES; g++) begin : g_pack
			assign wr_data[g*sscb_pkg::LANE_PW +: sscb_pkg::LANE_PW] =
				{PARITY_EN & lane_parity_bit_in[g], lane_in[g]};
			assign lane_parity_bit_out[g] =
				PARITY_EN & rd_data[g*sscb_pkg::LANE_PW + sscb_pkg::PAR_POS];
		end
	endgenerate

	// Lanes whose strobe was low at the load take the data of this edge
	wire logic wr_go = cyc_p2_r == sscb_pkg::SSCB_WRITE;
	wire logic [sscb_pkg::LANES-1:0] wr_lane = strb_p2_r;

	sscb_mem u_mem (
		.core_clk(core_clk),
		.ce(ce),
		.wr_en(wr_go),
		.wr_addr(addr_p2_r),
		.wr_lane(wr_lane),
		.wr_data(wr_data),
		.rd_addr(addr_p1_r),
		.rd_data(rd_data)
	);

	// =========================================================
	// Read outputs and drive enable
	// =========================================================
	// Enable is registered on the edge that loads the read register,
	// so data and enable always stand in the same cycle
	wire logic rd_go = cyc_p1_r == sscb_pkg::SSCB_READ;
	logic rd_vld_r;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_vld_r <= 1'b0;
		end else if (ce) begin
			rd_vld_r <= rd_go;
		end
	end

	logic [sscb_pkg::LANE_W-1:0] lane_out [sscb_pkg::LANES];

	generate
		for (g = 0; g < sscb_pkg::LANES; g++) begin : g_unpack
			assign lane_out[g] = rd_data[g*sscb_pkg::LANE_PW +: sscb_pkg::LANE_W];
		end
	endgenerate

	assign byte_lane_a_out = lane_out[0];
	assign byte_lane_b_out = lane_out[1];
	assign byte_lane_c_out = lane_out[2];
	assign byte_lane_d_out = lane_out[3];
	assign data_oe_n = {sscb_pkg::LANES{!rd_vld_r}};
endmodule : sscb_port

/* File: verification/sscb_port_chk.sv */
// Purpose: Port timing checks for the SRAM cycle and burst port
// Assumes: Read data and drive enable follow the address edge by one enabled edge
// Notes: Bound into sscb_port
module sscb_port_chk (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Control
	input wire logic clk_enable_n,
	input wire logic advance_or_load_n,
	input wire logic read_write_n,
	// Read side
	input wire logic [sscb_pkg::LANE_W-1:0] byte_lane_a_out,
	input wire logic [sscb_pkg::LANE_W-1:0] byte_lane_b_out,
	input wire logic [sscb_pkg::LANE_W-1:0] byte_lane_c_out,
	input wire logic [sscb_pkg::LANE_W-1:0] byte_lane_d_out,
	input wire logic [sscb_pkg::LANES-1:0] lane_parity_bit_out,
	input wire logic [sscb_pkg::LANES-1:0] data_oe_n
);
	// ====
	// Checks
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence rd_load; !clk_enable_n && !advance_or_load_n && read_write_n; endsequence
	sequence wr_load; !clk_enable_n && !advance_or_load_n && !read_write_n; endsequence
	sequence adv_step; !clk_enable_n && advance_or_load_n; endsequence
	sequence live; !clk_enable_n; endsequence
	AST_OE_READ: assert property (rd_load ##1 live |=> data_oe_n == 4'h0)
		else $error("read load not driven");
	AST_OE_WRITE: assert property (wr_load ##1 live |=> data_oe_n == 4'hf)
		else $error("write load drove bus");
	AST_RD_BURST: assert property (rd_load ##1 adv_step ##1 live |=> data_oe_n == 4'h0)
		else $error("read burst changed type");
	AST_WR_BURST: assert property (wr_load ##1 adv_step ##1 live |=> data_oe_n == 4'hf)
		else $error("write burst changed type");
	AST_FREEZE_OE: assert property (clk_enable_n |=> $stable(data_oe_n))
		else $error("enable moved while frozen");
	AST_FREEZE_DATA: assert property (clk_enable_n && data_oe_n == 4'h0 |=>
		$stable({lane_parity_bit_out, byte_lane_d_out, byte_lane_c_out, byte_lane_b_out,
		byte_lane_a_out})) else $error("read data moved while frozen");
	AST_OE_UNIFORM: assert property (data_oe_n == 4'h0 || data_oe_n == 4'hf)
		else $error("lane enables differ");
	AST_RST_IDLE: assert property ($rose(rst_n) |-> data_oe_n == 4'hf)
		else $error("bus driven after reset");
endmodule : sscb_port_chk

bind sscb_port sscb_port_chk u_chk (.*);

/* File: verification/sscb_ctrl_model.sv */
// Purpose: Bus-master model issuing four-word bursts
// Assumes: Drives on the falling edge, with random one-cycle stalls
// Notes: Ignored direction and strobes are flipped on advance cycles; the address is held
module sscb_ctrl_model (
	// Clock
	input wire logic core_clk,
	// Control
	output logic clk_enable_n, advance_or_load_n, read_write_n,
	output logic [sscb_pkg::ADDR_W-1:0] addr,
	output logic byte_write_strobe_a_n, byte_write_strobe_b_n,
	output logic byte_write_strobe_c_n, byte_write_strobe_d_n,
	// Data
	output logic [7:0] byte_lane_a_in, byte_lane_b_in, byte_lane_c_in, byte_lane_d_in,
	output logic [3:0] lane_parity_bit_in,
	input wire logic [7:0] byte_lane_a_out, byte_lane_b_out, byte_lane_c_out, byte_lane_d_out,
	input wire logic [3:0] lane_parity_bit_out
);
	logic [3:0] sn;
	logic [35:0] wd;
	logic [35:0] rd;
	assign {byte_write_strobe_d_n, byte_write_strobe_c_n, byte_write_strobe_b_n,
		byte_write_strobe_a_n} = sn;
	assign {lane_parity_bit_in[3], byte_lane_d_in, lane_parity_bit_in[2], byte_lane_c_in,
		lane_parity_bit_in[1], byte_lane_b_in, lane_parity_bit_in[0], byte_lane_a_in} = wd;
	assign rd = {lane_parity_bit_out[3], byte_lane_d_out, lane_parity_bit_out[2],
		byte_lane_c_out, lane_parity_bit_out[1], byte_lane_b_out, lane_parity_bit_out[0],
		byte_lane_a_out};
	initial begin
		clk_enable_n = 1'b0;
		advance_or_load_n = 1'b1;
		read_write_n = 1'b1;
		addr = '0;
		sn = 4'hf;
		wd = '0;
	end
	// ====
	// Burst: load, three advances, then harmless read loads
	task automatic burst(input bit wr, input logic [17:0] a, input logic [3:0] s,
		input logic [35:0] wds [4], output logic [35:0] rds [4]);
		for (int t = 0; t < 7; t++) begin
			@(negedge core_clk);
			if ($urandom_range(3) == 0) begin
				clk_enable_n = 1'b1;
				@(negedge core_clk);
				clk_enable_n = 1'b0;
			end
			if (t inside {[2:5]}) rds[t-2] = rd;
			advance_or_load_n = t inside {[1:3]};
			read_write_n = (t == 0) ? !wr : (t < 4) ? wr : 1'b1;
			sn = (t == 0) ? s : (t < 4) ? ~s : 4'hf;
			addr = a;
			wd = t inside {[2:5]} ? wds[t-2] : ~wd;
		end
	endtask : burst
endmodule : sscb_ctrl_model

/* File: verification/sscb_port_tb.sv */
// Purpose: Self-checking bench for the SRAM cycle and burst port
// Assumes: Seeded random data, strobes and stalls
// Notes: Both burst orders, each after its own reset
module sscb_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk, rst_n, clk_enable_n, advance_or_load_n, read_write_n, burst_order_select;
	logic [sscb_pkg::ADDR_W-1:0] addr;
	logic byte_write_strobe_a_n, byte_write_strobe_b_n;
	logic byte_write_strobe_c_n, byte_write_strobe_d_n;
	logic [7:0] byte_lane_a_in, byte_lane_b_in, byte_lane_c_in, byte_lane_d_in;
	logic [7:0] byte_lane_a_out, byte_lane_b_out, byte_lane_c_out, byte_lane_d_out;
	logic [3:0] lane_parity_bit_in, lane_parity_bit_out, data_oe_n;
	int miscompares, num_checks;
	logic [35:0] ref_mem [int];
	logic [3:0] nf_parity, nf_oe_n;
	sscb_port dut (.*);
	sscb_ctrl_model ctrl (.*);
	// 32-bit form on the same stimulus: parity must read back as zero
	sscb_port #(.PARITY_EN(1'b0)) dut_nf (.core_clk, .rst_n, .clk_enable_n,
		.advance_or_load_n, .read_write_n, .addr, .burst_order_select,
		.byte_write_strobe_a_n, .byte_write_strobe_b_n, .byte_write_strobe_c_n,
		.byte_write_strobe_d_n, .byte_lane_a_in, .byte_lane_b_in, .byte_lane_c_in,
		.byte_lane_d_in, .lane_parity_bit_in, .byte_lane_a_out(), .byte_lane_b_out(),
		.byte_lane_c_out(), .byte_lane_d_out(), .lane_parity_bit_out(nf_parity),
		.data_oe_n(nf_oe_n));
	always @(negedge core_clk) if (rst_n && nf_oe_n == 4'h0) begin
		check("nf_parity", 36'(nf_parity), 36'h0);
	end
	function automatic logic [17:0] baddr(logic [17:0] a, int k);
		return {a[17:2], burst_order_select ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k)};
	endfunction : baddr
	function automatic logic [35:0] merge(logic [35:0] old, logic [35:0] nw, logic [3:0] s);
		for (int g = 0; g < 4; g++)
			if (!s[g]) old[g*9 +: 9] = nw[g*9 +: 9];
		return old;
	endfunction : merge
	task automatic check(string what, logic [35:0] seen, logic [35:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	initial begin
		#50us;
		miscompares++;
		wrap_up();
	end
	// ====
	// Write full, write partial, read back; corner addresses first
	initial begin
		logic [35:0] wd [4];
		logic [35:0] rd [4];
		logic [17:0] a;
		logic [3:0] s;
		void'($urandom(99));
		for (int o = 0; o < 2; o++) begin
			rst_n = 1'b0;
			burst_order_select = o[0];
			repeat (4) @(negedge core_clk);
			check("oe_in_reset", 36'(data_oe_n), 36'hf);
			rst_n = 1'b1;
			for (int i = 0; i < 12; i++) begin
				a = (i == 0) ? '0 : (i == 1) ? '1 : 18'($urandom);
				for (int p = 0; p < 3; p++) begin
					s = (p == 0) ? 4'h0 : (p == 1) ? 4'($urandom) : 4'hf;
					foreach (wd[k]) wd[k] = {4'($urandom), $urandom};
					ctrl.burst(p < 2, a, s, wd, rd);
					foreach (wd[k]) begin
						if (p < 2) ref_mem[baddr(a, k)] = merge(ref_mem.exists(baddr(a, k)) ?
							ref_mem[baddr(a, k)] : '0, wd[k], s);
						else check("read_word", rd[k], ref_mem[baddr(a, k)]);
					end
				end
			end
		end
		wrap_up();
	end
endmodule : sscb_port_tb
